// [verilog/bank1_special_register_map.sv]
// Bank 1 special register map with APB access and common locations
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ns
`include "bank1_sfr_cfg.svh"

// Functional notes
// - Upper program counter byte has no address; only the latch is visible.
// - Latch bits go to program counter 12..8 only on a branch.
// - Indirect, pc low, status, pointer, latch, irq control in every bank.
// - Small-package variant omits port D/E registers; they read zero.
// - Unimplemented bank 1 locations read zero and ignore writes.
// - Unimplemented bits inside registers read zero.
// - Interrupt flags set on their event regardless of any enable.
// - Power-on and brown-out load port C direction with all ones.
// - Pin and watchdog resets are reset sources with own values.
// - One peripheral flag bit per peripheral interrupt source.
module bank1_special_register_map
	import bank1_sfr_pkg::*;
#(
	parameter bit SMALL_PACKAGE = 1'b0
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic brown_out_reset_i,
	input wire logic external_reset_pin_i,
	input wire logic watchdog_timeout_i,
	input wire logic branch_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [10:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [3:0] pstrb_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic [2:0] core_irq_evt_i,
	input wire logic [7:0] periph_irq_evt_i,
	input wire logic [1:0] parallel_buf_full_i,
	input wire logic parallel_overflow_i,
	input wire logic [5:0] ssp_state_i,
	input wire logic tx_shift_empty_i,
	output logic [4:0] pc_upper_o,
	output logic [7:0] program_counter_low_o,
	output logic [7:0] cpu_status_flags_o,
	output logic [7:0] timer0_and_pullup_options_o,
	output logic [7:0] port_a_direction_o,
	output logic [7:0] port_b_direction_o,
	output logic [7:0] port_c_direction_o,
	output logic [7:0] port_d_direction_o,
	output logic [7:0] port_e_direction_o,
	output logic [7:0] interrupt_control_o,
	output logic [7:0] peripheral_irq_enables_1_o,
	output logic [7:0] peripheral_irq_enables_2_o,
	output logic [7:0] peripheral_irq_flags_1_o,
	output logic [7:0] timer2_period_o,
	output logic [7:0] serial_port_slave_address_o,
	output logic [7:0] uart_transmit_control_o,
	output logic [7:0] baud_rate_divisor_o,
	output logic [7:0] analog_pin_config_o
);
	// ======================================================================
	// Reset classification
	reset_kind_t rst_kind;
	logic soft_rst;

	always_comb begin
		if (brown_out_reset_i) begin
			rst_kind = RST_POWER;
		end else if (external_reset_pin_i || watchdog_timeout_i) begin
			rst_kind = RST_OTHER;
		end else begin
			rst_kind = RST_NONE;
		end
	end
	assign soft_rst = (rst_kind != RST_NONE);

	// ======================================================================
	// Address decode
	logic [8:0] idx;
	logic [8:0] tgt;
	logic [8:0] common_idx;
	logic bank_ok;
	logic [7:0] pointer;
	logic [7:0] status;
	reg_sel_t sel;

	assign idx = paddr_i[10:2];

	// Indirect access swaps in the pointer and its own bank bit
	always_comb begin
		if (idx[6:0] == `INDIRECT_OFFSET) begin
			tgt = {status[7], pointer};
			bank_ok = 1'b1;
		end else begin
			tgt = idx;
			bank_ok = (idx[8:7] == status[6:5]);
		end
	end
	assign common_idx = {`BANK_ONE, tgt[6:0]};

	always_comb begin
		sel = SEL_NONE;
		case (common_idx)
			`IDX_PC_LOW: begin
				sel = SEL_PC_LOW;
			end
			`IDX_STATUS: begin
				sel = SEL_STATUS;
			end
			`IDX_POINTER: begin
				sel = SEL_POINTER;
			end
			`IDX_PC_LATCH: begin
				sel = SEL_PC_LATCH;
			end
			`IDX_IRQ_CTRL: begin
				sel = SEL_IRQ_CTRL;
			end
			default: begin
				// Indirect location is not physical; it stays SEL_NONE
				if (bank_ok && tgt == `IDX_PERIPH_FLAGS) begin
					sel = SEL_PERIPH_FLAGS;
				end else if (bank_ok && tgt[8:7] == `BANK_ONE) begin
					case (tgt)
						`IDX_OPTIONS: sel = SEL_OPTIONS;
						`IDX_DIR_A: sel = SEL_DIR_A;
						`IDX_DIR_B: sel = SEL_DIR_B;
						`IDX_DIR_C: sel = SEL_DIR_C;
						`IDX_DIR_D: sel = SMALL_PACKAGE ? SEL_NONE : SEL_DIR_D;
						`IDX_DIR_E: sel = SMALL_PACKAGE ? SEL_NONE : SEL_DIR_E;
						`IDX_IRQ_EN1: sel = SEL_IRQ_EN1;
						`IDX_IRQ_EN2: sel = SEL_IRQ_EN2;
						`IDX_RESET_CAUSE: sel = SEL_RESET_CAUSE;
						`IDX_T2_PERIOD: sel = SEL_T2_PERIOD;
						`IDX_SSP_ADDR: sel = SEL_SSP_ADDR;
						`IDX_SSP_STATUS: sel = SEL_SSP_STATUS;
						`IDX_TX_CTRL: sel = SEL_TX_CTRL;
						`IDX_BAUD: sel = SEL_BAUD;
						`IDX_ANALOG: sel = SEL_ANALOG;
						default: sel = SEL_NONE;
					endcase
				end
			end
		endcase
	end

	// ======================================================================
	// APB handshake: no wait states, write lands at the completing edge
	logic wr;
	logic [7:0] wdata;

	assign wr = psel_i && penable_i && pready_o && pwrite_i && pstrb_i[0];
	assign wdata = pwdata_i[7:0];

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pready_o <= 1'b0;
		end else begin
			pready_o <= psel_i && !penable_i;
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pslverr_o <= 1'b0;
		end else begin
			pslverr_o <= 1'b0;
		end
	end

	// ======================================================================
	// Plain registers
	logic [7:0] options;
	logic [7:0] pc_low;
	logic [7:0] dir_a;
	logic [7:0] dir_b;
	logic [7:0] dir_c;
	logic [7:0] dir_d;
	logic [7:0] dir_e_ctl;
	logic [7:0] pc_latch;
	logic [7:0] irq_en1;
	logic [7:0] irq_en2;
	logic [7:0] t2_period;
	logic [7:0] ssp_addr;
	logic [7:0] ssp_ctl;
	logic [7:0] tx_ctl;
	logic [7:0] baud;
	logic [7:0] analog;

	sfr_cell #(.RST_VAL(`RST_OPTIONS), .WR_MASK(`WM_ALL)) u_options (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i), .soft_rst_i(soft_rst),
		.we_i(wr && sel == SEL_OPTIONS), .wdata_i(wdata), .q_o(options));
	sfr_cell #(.RST_VAL(`RST_ZERO), .WR_MASK(`WM_ALL)) u_pc_low (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i), .soft_rst_i(soft_rst),
		.we_i(wr && sel == SEL_PC_LOW), .wdata_i(wdata), .q_o(pc_low));
	sfr_cell #(.RST_VAL(`RST_DIR_A), .WR_MASK(`WM_DIR_A)) u_dir_a (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i), .soft_rst_i(soft_rst),
		.we_i(wr && sel == SEL_DIR_A), .wdata_i(wdata), .q_o(dir_a));
	sfr_cell #(.RST_VAL(`RST_DIR_FULL), .WR_MASK(`WM_ALL)) u_dir_b (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i), .soft_rst_i(soft_rst),
		.we_i(wr && sel == SEL_DIR_B), .wdata_i(wdata), .q_o(dir_b));
	// All inputs after power-on or brown-out
	sfr_cell #(.RST_VAL(`RST_DIR_FULL), .WR_MASK(`WM_ALL)) u_dir_c (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i), .soft_rst_i(soft_rst),
		.we_i(wr && sel == SEL_DIR_C), .wdata_i(wdata), .q_o(dir_c));
	sfr_cell #(.RST_VAL(`RST_DIR_FULL), .WR_MASK(`WM_ALL)) u_dir_d (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i), .soft_rst_i(soft_rst),
		.we_i(wr && sel == SEL_DIR_D), .wdata_i(wdata), .q_o(dir_d));
	sfr_cell #(.RST_VAL(`RST_DIR_E), .WR_MASK(`WM_DIR_E)) u_dir_e (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i), .soft_rst_i(soft_rst),
		.we_i(wr && sel == SEL_DIR_E), .wdata_i(wdata), .q_o(dir_e_ctl));
	sfr_cell #(.RST_VAL(`RST_ZERO), .WR_MASK(`WM_PC_LATCH)) u_pc_latch (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i), .soft_rst_i(soft_rst),
		.we_i(wr && sel == SEL_PC_LATCH), .wdata_i(wdata), .q_o(pc_latch));
	sfr_cell #(.RST_VAL(`RST_ZERO), .WR_MASK(`WM_ALL)) u_irq_en1 (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i), .soft_rst_i(soft_rst),
		.we_i(wr && sel == SEL_IRQ_EN1), .wdata_i(wdata), .q_o(irq_en1));
	sfr_cell #(.RST_VAL(`RST_ZERO), .WR_MASK(`WM_IRQ_EN2)) u_irq_en2 (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i), .soft_rst_i(soft_rst),
		.we_i(wr && sel == SEL_IRQ_EN2), .wdata_i(wdata), .q_o(irq_en2));
	sfr_cell #(.RST_VAL(`RST_T2_PERIOD), .WR_MASK(`WM_ALL)) u_t2_period (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i), .soft_rst_i(soft_rst),
		.we_i(wr && sel == SEL_T2_PERIOD), .wdata_i(wdata), .q_o(t2_period));
	sfr_cell #(.RST_VAL(`RST_ZERO), .WR_MASK(`WM_ALL)) u_ssp_addr (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i), .soft_rst_i(soft_rst),
		.we_i(wr && sel == SEL_SSP_ADDR), .wdata_i(wdata), .q_o(ssp_addr));
	sfr_cell #(.RST_VAL(`RST_ZERO), .WR_MASK(`WM_SSP_STATUS)) u_ssp_ctl (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i), .soft_rst_i(soft_rst),
		.we_i(wr && sel == SEL_SSP_STATUS), .wdata_i(wdata), .q_o(ssp_ctl));
	sfr_cell #(.RST_VAL(`RST_ZERO), .WR_MASK(`WM_TX_CTRL)) u_tx_ctl (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i), .soft_rst_i(soft_rst),
		.we_i(wr && sel == SEL_TX_CTRL), .wdata_i(wdata), .q_o(tx_ctl));
	sfr_cell #(.RST_VAL(`RST_ZERO), .WR_MASK(`WM_ALL)) u_baud (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i), .soft_rst_i(soft_rst),
		.we_i(wr && sel == SEL_BAUD), .wdata_i(wdata), .q_o(baud));
	sfr_cell #(.RST_VAL(`RST_ZERO), .WR_MASK(`WM_ANALOG)) u_analog (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i), .soft_rst_i(soft_rst),
		.we_i(wr && sel == SEL_ANALOG), .wdata_i(wdata), .q_o(analog));

	// ======================================================================
	// Event flags
	logic [7:0] irq_ctl;
	logic [2:0] core_flags;
	logic [7:0] periph_flags;
	logic [7:0] periph_set;
	logic overflow_flag;

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			irq_ctl <= `RST_ZERO;
		end else if (soft_rst) begin
			irq_ctl <= `RST_ZERO;
		end else if (wr && sel == SEL_IRQ_CTRL) begin
			irq_ctl <= wdata & `WM_IRQ_CTRL;
		end
	end

	irq_flag_bank #(.WIDTH(3), .WR_MASK(3'h7)) u_core_flags (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i), .soft_rst_i(soft_rst),
		.we_i(wr && sel == SEL_IRQ_CTRL), .wdata_i(wdata[2:0]),
		.set_i(core_irq_evt_i), .q_o(core_flags));

	// Parallel-port source does not exist on the small package
	always_comb begin
		periph_set = periph_irq_evt_i;
		if (SMALL_PACKAGE) begin
			periph_set[`BIT_PARALLEL] = 1'b0;
		end
	end

	irq_flag_bank #(.WIDTH(8), .WR_MASK(`WM_PERIPH_FLAGS)) u_periph_flags (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i), .soft_rst_i(soft_rst),
		.we_i(wr && sel == SEL_PERIPH_FLAGS), .wdata_i(wdata),
		.set_i(periph_set), .q_o(periph_flags));

	irq_flag_bank #(.WIDTH(1), .WR_MASK(1'b1)) u_overflow (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i), .soft_rst_i(soft_rst),
		.we_i(wr && sel == SEL_DIR_E), .wdata_i(wdata[`BIT_OVERFLOW]),
		.set_i(parallel_overflow_i), .q_o(overflow_flag));

	// ======================================================================
	// Status, pointer and reset cause
	logic [7:0] reset_cause;

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			status <= `RST_STATUS;
		end else begin
			case (rst_kind)
				RST_POWER: begin
					status <= `RST_STATUS;
				end
				RST_OTHER: begin
					// Arithmetic flags survive a pin or watchdog reset
					status[7:5] <= 3'h0;
					status[`BIT_TIMEOUT] <= !watchdog_timeout_i;
				end
				default: begin
					if (wr && sel == SEL_STATUS) begin
						status <= (wdata & `WM_STATUS)
							| (status & ~`WM_STATUS);
					end
				end
			endcase
		end
	end

	// Pointer is left alone by pin and watchdog resets
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pointer <= `RST_ZERO;
		end else if (rst_kind == RST_POWER) begin
			pointer <= `RST_ZERO;
		end else if (wr && sel == SEL_POINTER) begin
			pointer <= wdata;
		end
	end

	// Cause bits read zero after the matching reset until software sets them
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			reset_cause <= `RST_ZERO;
		end else if (rst_kind == RST_POWER) begin
			reset_cause[`BIT_BROWN_OUT] <= 1'b0;
		end else if (wr && sel == SEL_RESET_CAUSE) begin
			reset_cause <= wdata & `WM_RESET_CAUSE;
		end
	end

	// ======================================================================
	// Program counter upper bits: only loaded on a branch
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pc_upper_o <= 5'h00;
		end else if (soft_rst) begin
			pc_upper_o <= 5'h00;
		end else if (branch_i) begin
			pc_upper_o <= pc_latch[4:0];
		end
	end

	// ======================================================================
	// Read data, captured in the setup phase
	logic [7:0] rd;
	logic [7:0] dir_e_view;

	assign dir_e_view = dir_e_ctl | {parallel_buf_full_i, overflow_flag,
		5'h00};

	always_comb begin
		case (sel)
			SEL_OPTIONS: rd = options;
			SEL_PC_LOW: rd = pc_low;
			SEL_STATUS: rd = status;
			SEL_POINTER: rd = pointer;
			SEL_DIR_A: rd = dir_a;
			SEL_DIR_B: rd = dir_b;
			SEL_DIR_C: rd = dir_c;
			SEL_DIR_D: rd = dir_d;
			SEL_DIR_E: rd = dir_e_view;
			SEL_PC_LATCH: rd = pc_latch;
			SEL_IRQ_CTRL: rd = {irq_ctl[7:3], core_flags};
			SEL_IRQ_EN1: rd = irq_en1;
			SEL_IRQ_EN2: rd = irq_en2;
			SEL_RESET_CAUSE: rd = reset_cause;
			SEL_T2_PERIOD: rd = t2_period;
			SEL_SSP_ADDR: rd = ssp_addr;
			SEL_SSP_STATUS: rd = ssp_ctl | {2'h0, ssp_state_i};
			SEL_TX_CTRL: rd = tx_ctl | {6'h00, tx_shift_empty_i, 1'b0};
			SEL_BAUD: rd = baud;
			SEL_ANALOG: rd = analog;
			SEL_PERIPH_FLAGS: rd = periph_flags;
			default: rd = 8'h00;
		endcase
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			prdata_o <= 32'h00000000;
		end else if (psel_i && !penable_i) begin
			prdata_o <= {24'h000000, rd};
		end
	end

	// ======================================================================
	// Register outputs
	assign program_counter_low_o = pc_low;
	assign cpu_status_flags_o = status;
	assign timer0_and_pullup_options_o = options;
	assign port_a_direction_o = dir_a;
	assign port_b_direction_o = dir_b;
	assign port_c_direction_o = dir_c;
	assign port_d_direction_o = dir_d;
	assign port_e_direction_o = dir_e_ctl;
	assign interrupt_control_o = {irq_ctl[7:3], core_flags};
	assign peripheral_irq_enables_1_o = irq_en1;
	assign peripheral_irq_enables_2_o = irq_en2;
	assign peripheral_irq_flags_1_o = periph_flags;
	assign timer2_period_o = t2_period;
	assign serial_port_slave_address_o = ssp_addr;
	assign uart_transmit_control_o = tx_ctl;
	assign baud_rate_divisor_o = baud;
	assign analog_pin_config_o = analog;
endmodule

// [verilog/bank1_sfr_cfg.svh]
// Register indices, reset values and write masks of the bank 1 map
`ifndef BANK1_SFR_CFG_SVH
`define BANK1_SFR_CFG_SVH

// ==========================================================================
// Bank selection
`define BANK_ZERO 2'h0
`define BANK_ONE 2'h1
`define INDIRECT_OFFSET 7'h00

// ==========================================================================
// Register indices (byte address is four times the index)
`define IDX_INDIRECT 9'h080
`define IDX_OPTIONS 9'h081
`define IDX_PC_LOW 9'h082
`define IDX_STATUS 9'h083
`define IDX_POINTER 9'h084
`define IDX_DIR_A 9'h085
`define IDX_DIR_B 9'h086
`define IDX_DIR_C 9'h087
`define IDX_DIR_D 9'h088
`define IDX_DIR_E 9'h089
`define IDX_PC_LATCH 9'h08A
`define IDX_IRQ_CTRL 9'h08B
`define IDX_IRQ_EN1 9'h08C
`define IDX_IRQ_EN2 9'h08D
`define IDX_RESET_CAUSE 9'h08E
`define IDX_T2_PERIOD 9'h092
`define IDX_SSP_ADDR 9'h093
`define IDX_SSP_STATUS 9'h094
`define IDX_TX_CTRL 9'h098
`define IDX_BAUD 9'h099
`define IDX_ANALOG 9'h09F
`define IDX_PERIPH_FLAGS 9'h00C

// ==========================================================================
// Reset values
`define RST_OPTIONS 8'hFF
`define RST_ZERO 8'h00
`define RST_STATUS 8'h18
`define RST_DIR_A 8'h3F
`define RST_DIR_FULL 8'hFF
`define RST_DIR_E 8'h07
`define RST_T2_PERIOD 8'hFF

// ==========================================================================
// Writable bit masks; other bits read as zero or come from hardware
`define WM_ALL 8'hFF
`define WM_STATUS 8'hE7
`define WM_DIR_A 8'h3F
`define WM_DIR_E 8'h37
`define WM_PC_LATCH 8'h1F
`define WM_IRQ_CTRL 8'hF8
`define WM_IRQ_EN2 8'h01
`define WM_RESET_CAUSE 8'h03
`define WM_SSP_STATUS 8'hC0
`define WM_TX_CTRL 8'hF5
`define WM_ANALOG 8'h07
`define WM_PERIPH_FLAGS 8'hCF

// ==========================================================================
// Bit positions
`define BIT_TIMEOUT 4
`define BIT_POWER_DOWN 3
`define BIT_POWER_ON 1
`define BIT_BROWN_OUT 0
`define BIT_PARALLEL 7
`define BIT_OVERFLOW 5

`endif

// [verilog/bank1_sfr_pkg.sv]
// Types shared by the bank 1 register map
package bank1_sfr_pkg;
	typedef enum {
		SEL_NONE, SEL_OPTIONS, SEL_PC_LOW, SEL_STATUS, SEL_POINTER,
		SEL_DIR_A, SEL_DIR_B, SEL_DIR_C, SEL_DIR_D, SEL_DIR_E,
		SEL_PC_LATCH, SEL_IRQ_CTRL, SEL_IRQ_EN1, SEL_IRQ_EN2,
		SEL_RESET_CAUSE, SEL_T2_PERIOD, SEL_SSP_ADDR, SEL_SSP_STATUS,
		SEL_TX_CTRL, SEL_BAUD, SEL_ANALOG, SEL_PERIPH_FLAGS
	} reg_sel_t;
	typedef enum {
		RST_NONE, RST_POWER, RST_OTHER
	} reset_kind_t;
endpackage

// [verilog/sfr_cell.sv]
// One plain read/write special register with masked bits
`timescale 1ns/1ns
module sfr_cell #(
	parameter logic [7:0] RST_VAL = 8'h00,
	parameter logic [7:0] WR_MASK = 8'hFF
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic soft_rst_i,
	input wire logic we_i,
	input wire logic [7:0] wdata_i,
	output logic [7:0] q_o
);
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			q_o <= RST_VAL;
		end else if (soft_rst_i) begin
			q_o <= RST_VAL;
		end else if (we_i) begin
			q_o <= wdata_i & WR_MASK;
		end
	end
endmodule

// [verilog/irq_flag_bank.sv]
// Sticky event flags; a hardware set wins over a software write
`timescale 1ns/1ns
module irq_flag_bank #(
	parameter int WIDTH = 8,
	parameter logic [WIDTH-1:0] WR_MASK = '1
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic soft_rst_i,
	input wire logic we_i,
	input wire logic [WIDTH-1:0] wdata_i,
	input wire logic [WIDTH-1:0] set_i,
	output logic [WIDTH-1:0] q_o
);
	logic [WIDTH-1:0] next_q;

	always_comb begin
		next_q = q_o;
		if (we_i) begin
			next_q = (wdata_i & WR_MASK) | (q_o & ~WR_MASK);
		end
		next_q = next_q | set_i;
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			q_o <= '0;
		end else if (soft_rst_i) begin
			q_o <= '0;
		end else begin
			q_o <= next_q;
		end
	end
endmodule

// [verification/bank1_special_register_map_sva.sv]
// Port-level checker for the bank 1 register map
`timescale 1ns/1ns
module bank1_special_register_map_sva (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic brown_out_reset_i,
	input wire logic external_reset_pin_i,
	input wire logic watchdog_timeout_i,
	input wire logic branch_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o,
	input wire logic [2:0] core_irq_evt_i,
	input wire logic [7:0] periph_irq_evt_i,
	input wire logic [4:0] pc_upper_o,
	input wire logic [7:0] cpu_status_flags_o,
	input wire logic [7:0] port_a_direction_o,
	input wire logic [7:0] port_c_direction_o,
	input wire logic [7:0] interrupt_control_o,
	input wire logic [7:0] peripheral_irq_flags_1_o,
	input wire logic [7:0] peripheral_irq_enables_2_o,
	input wire logic [7:0] analog_pin_config_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	// Synchronous resets may legally move any register
	logic quiet;
	assign quiet = !brown_out_reset_i && !external_reset_pin_i
		&& !watchdog_timeout_i;
	// ==================================================================
	// Bus
	a_ready_after_setup: assert property (quiet && psel_i && !penable_i
		|=> pready_o) else $error("no ready after setup");
	a_ready_single: assert property (pready_o |=> !pready_o)
		else $error("ready held too long");
	a_no_error: assert property (!pslverr_o)
		else $error("error response seen");
	a_read_upper_zero: assert property (prdata_o[31:8] == 24'h000000)
		else $error("read data upper bits set");
	a_read_data_holds: assert property (quiet && !(psel_i && !penable_i)
		|=> $stable(prdata_o)) else $error("read data moved");
	// ==================================================================
	// Registers and events
	a_latch_only_branch: assert property (
		!branch_i && quiet |=> $stable(pc_upper_o))
		else $error("upper pc moved without branch");
	a_periph_flag_sets: assert property (
		quiet && periph_irq_evt_i[6:0] != 7'h00 |=>
		(peripheral_irq_flags_1_o[6:0] & $past(periph_irq_evt_i[6:0]))
		== $past(periph_irq_evt_i[6:0])) else $error("flag not set");
	a_core_flag_sets: assert property (
		quiet && core_irq_evt_i != 3'h0 |=>
		(interrupt_control_o[2:0] & $past(core_irq_evt_i))
		== $past(core_irq_evt_i)) else $error("core flag not set");
	a_brown_dir_c: assert property (
		brown_out_reset_i |=> port_c_direction_o == 8'hFF)
		else $error("port c direction not all inputs");
	a_pin_reset_status: assert property (
		external_reset_pin_i && !watchdog_timeout_i && !brown_out_reset_i
		|=> cpu_status_flags_o[7:4] == 4'h1)
		else $error("status wrong after pin reset");
	a_wdt_status: assert property (
		watchdog_timeout_i && !brown_out_reset_i
		|=> !cpu_status_flags_o[4]) else $error("timeout bit not cleared");
	a_unimpl_bits_zero: assert property (
		port_a_direction_o[7:6] == 2'h0
		&& peripheral_irq_enables_2_o[7:1] == 7'h00
		&& analog_pin_config_o[7:3] == 5'h00)
		else $error("unimplemented bit set");
	c_branch: cover property (branch_i);
	c_brown: cover property (brown_out_reset_i);
	c_wdt: cover property (watchdog_timeout_i);
	c_read: cover property (pready_o && prdata_o[7:0] != 8'h00);
endmodule
bind bank1_special_register_map bank1_special_register_map_sva sva_i (
	.clk_i(clk_i), .sys_rst_i(sys_rst_i),
	.brown_out_reset_i(brown_out_reset_i),
	.external_reset_pin_i(external_reset_pin_i),
	.watchdog_timeout_i(watchdog_timeout_i), .branch_i(branch_i),
	.psel_i(psel_i), .penable_i(penable_i), .prdata_o(prdata_o),
	.pready_o(pready_o), .pslverr_o(pslverr_o),
	.core_irq_evt_i(core_irq_evt_i), .periph_irq_evt_i(periph_irq_evt_i),
	.pc_upper_o(pc_upper_o), .cpu_status_flags_o(cpu_status_flags_o),
	.port_a_direction_o(port_a_direction_o),
	.port_c_direction_o(port_c_direction_o),
	.interrupt_control_o(interrupt_control_o),
	.peripheral_irq_flags_1_o(peripheral_irq_flags_1_o),
	.peripheral_irq_enables_2_o(peripheral_irq_enables_2_o),
	.analog_pin_config_o(analog_pin_config_o));

// [verification/bank1_special_register_map_test.sv]
// Self-checking bench for the bank 1 register map over APB
`timescale 1ns/1ns
module bank1_special_register_map_test
	import bank1_sfr_pkg::*;
;
	logic clk_i, sys_rst_i, brown_out_reset_i, external_reset_pin_i;
	logic watchdog_timeout_i, branch_i, psel_i, penable_i, pwrite_i;
	logic [10:0] paddr_i;
	logic [31:0] pwdata_i, prdata_o;
	logic [3:0] pstrb_i;
	logic pready_o, pslverr_o, parallel_overflow_i, tx_shift_empty_i;
	logic [2:0] core_irq_evt_i;
	logic [7:0] periph_irq_evt_i, rd, status, dir_c, irq_ctl, flags1;
	logic [1:0] parallel_buf_full_i;
	logic [5:0] ssp_state_i;
	logic [4:0] pc_upper_o;
	logic [12:0][7:0] o;
	localparam logic [12:0][7:0] O_RST = 104'h00000000FF000007FFFF3FFF00;
	int failures, n_checks;
	localparam logic [8:0] RST_IDX [14] = '{9'h081, 9'h085, 9'h086,
		9'h087, 9'h088, 9'h089, 9'h08C, 9'h08D, 9'h092, 9'h093, 9'h094,
		9'h098, 9'h099, 9'h09F};
	localparam logic [7:0] RST_VAL [14] = '{8'hFF, 8'h3F, 8'hFF, 8'hFF,
		8'hFF, 8'h07, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h02, 8'h00,
		8'h00};
	localparam logic [8:0] HOLE [11] = '{9'h08F, 9'h090, 9'h091, 9'h095,
		9'h096, 9'h097, 9'h09A, 9'h09B, 9'h09C, 9'h09D, 9'h09E};
	localparam logic [8:0] MASK_IDX [4] = '{9'h085, 9'h08D, 9'h09F, 9'h098};
	localparam logic [7:0] MASK_VAL [4] = '{8'h3F, 8'h01, 8'h07, 8'hF7};
	localparam logic [7:0] ST_AFTER [3] = '{8'h18, 8'h1D, 8'h0D};

	bank1_special_register_map dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
		.brown_out_reset_i(brown_out_reset_i),
		.external_reset_pin_i(external_reset_pin_i),
		.watchdog_timeout_i(watchdog_timeout_i), .branch_i(branch_i),
		.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
		.paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
		.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
		.core_irq_evt_i(core_irq_evt_i), .periph_irq_evt_i(periph_irq_evt_i),
		.parallel_buf_full_i(parallel_buf_full_i),
		.parallel_overflow_i(parallel_overflow_i),
		.ssp_state_i(ssp_state_i), .tx_shift_empty_i(tx_shift_empty_i),
		.pc_upper_o(pc_upper_o), .program_counter_low_o(o[0]),
		.cpu_status_flags_o(status),
		.timer0_and_pullup_options_o(o[1]),
		.port_a_direction_o(o[2]), .port_b_direction_o(o[3]),
		.port_c_direction_o(dir_c), .port_d_direction_o(o[4]),
		.port_e_direction_o(o[5]), .interrupt_control_o(irq_ctl),
		.peripheral_irq_enables_1_o(o[6]),
		.peripheral_irq_enables_2_o(o[7]),
		.peripheral_irq_flags_1_o(flags1), .timer2_period_o(o[8]),
		.serial_port_slave_address_o(o[9]),
		.uart_transmit_control_o(o[10]),
		.baud_rate_divisor_o(o[11]), .analog_pin_config_o(o[12]));

	always #10 clk_i = ~clk_i;

	// ==================================================================
	// Tasks
	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [7:0] got,
		input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	// Ready and read data are taken at the edge that completes the access
	task automatic apb(input logic wr, input logic [8:0] idx,
		input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i <= wr;
		paddr_i <= {idx, 2'b00};
		pwdata_i <= {24'h000000, d};
		@(posedge clk_i);
		penable_i <= 1'b1;
		do begin
			@(posedge clk_i);
			n++;
		end while (pready_o !== 1'b1 && n < 50);
		if (n >= 50) begin
			failures++;
			$display("BAD ready at %h expected 1 seen %b", idx, pready_o);
		end
		rd = prdata_o[7:0];
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask

	task automatic wr(input logic [8:0] idx, input logic [7:0] d);
		apb(1'b1, idx, d);
	endtask

	task automatic rdc(input logic [8:0] idx, input logic [7:0] exp);
		apb(1'b0, idx, 8'h00);
		chk($sformatf("reg %h", idx), rd, exp);
	endtask

	task automatic events(input logic [7:0] p, input logic [2:0] c);
		@(posedge clk_i);
		periph_irq_evt_i <= p;
		core_irq_evt_i <= c;
		@(posedge clk_i);
		periph_irq_evt_i <= 8'h00;
		core_irq_evt_i <= 3'h0;
		@(negedge clk_i);
	endtask

	// ==================================================================
	// Sequence
	initial begin
		repeat (20000) @(posedge clk_i);
		failures++;
		test_done();
	end

	initial begin
		clk_i = 1'b0;
		sys_rst_i = 1'b1;
		{brown_out_reset_i, external_reset_pin_i, watchdog_timeout_i} = 3'h0;
		{branch_i, psel_i, penable_i, pwrite_i} = 4'h0;
		paddr_i = 11'h000;
		pwdata_i = 32'h00000000;
		pstrb_i = 4'hF;
		core_irq_evt_i = 3'h0;
		periph_irq_evt_i = 8'h00;
		parallel_buf_full_i = 2'h0;
		parallel_overflow_i = 1'b0;
		ssp_state_i = 6'h00;
		tx_shift_empty_i = 1'b1;
		failures = 0;
		n_checks = 0;
		repeat (12) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		rdc(9'h087, 8'h00);
		rdc(9'h183, 8'h18);
		wr(9'h18A, 8'hFF);
		rdc(9'h00A, 8'h1F);
		chk("pc upper", {3'h0, pc_upper_o}, 8'h00);
		@(posedge clk_i);
		branch_i <= 1'b1;
		@(posedge clk_i);
		branch_i <= 1'b0;
		@(negedge clk_i);
		chk("pc upper", {3'h0, pc_upper_o}, 8'h1F);
		wr(9'h10A, 8'h0A);
		chk("pc upper", {3'h0, pc_upper_o}, 8'h1F);
		wr(9'h083, 8'h20);
		rdc(9'h083, 8'h38);
		foreach (RST_IDX[i]) rdc(RST_IDX[i], RST_VAL[i]);
		for (int i = 0; i < 13; i++) begin
			chk($sformatf("out %0d", i), o[i], O_RST[i]);
		end
		foreach (HOLE[i]) begin
			wr(HOLE[i], 8'hFF);
			rdc(HOLE[i], 8'h00);
		end
		foreach (MASK_IDX[i]) begin
			wr(MASK_IDX[i], 8'hFF);
			rdc(MASK_IDX[i], MASK_VAL[i]);
		end
		events(8'h4F, 3'h7);
		chk("flags", flags1, 8'h4F);
		rdc(9'h08B, 8'h07);
		wr(9'h083, 8'h00);
		rdc(9'h00C, 8'h4F);
		wr(9'h00C, 8'h00);
		wr(9'h00B, 8'h00);
		rdc(9'h00C, 8'h00);
		events(8'h02, 3'h0);
		rdc(9'h00C, 8'h02);
		chk("irq control", irq_ctl, 8'h00);
		for (int k = 0; k < 3; k++) begin
			wr(9'h083, 8'h25);
			wr(9'h087, 8'h00);
			@(posedge clk_i);
			brown_out_reset_i <= (k == 0);
			external_reset_pin_i <= (k == 1);
			watchdog_timeout_i <= (k == 2);
			@(posedge clk_i);
			{brown_out_reset_i, external_reset_pin_i} <= 2'h0;
			watchdog_timeout_i <= 1'b0;
			rdc(9'h083, ST_AFTER[k]);
			chk("port c dir", dir_c, 8'hFF);
		end
		test_done();
	end
endmodule
